// file: rtl/bpb_cfg.svh
// register indices, reset values and field constants of the port bank
`ifndef BPB_CFG_SVH
`define BPB_CFG_SVH

// register indices; byte address is four times the index
`define BPB_IDX_A_DATA   8'hc0
`define BPB_IDX_A_DIR    8'hc1
`define BPB_IDX_B_DATA   8'hc2
`define BPB_IDX_B_DIR    8'hc3
`define BPB_IDX_C_DATA   8'hc4
`define BPB_IDX_C_DIR    8'hc5
`define BPB_IDX_A_OD     8'he4
`define BPB_IDX_B_FUNC   8'hf1
`define BPB_IDX_A_PC     8'hf8
`define BPB_IDX_B_PC     8'hf9
`define BPB_IDX_C_PC     8'hfa

// index field inside the byte address
`define BPB_IDX_MSB      9
`define BPB_IDX_LSB      2

`define BPB_CFG_RESET    8'h00
`define BPB_PIN_IDLE     8'hff
`define BPB_RESP_OKAY    2'h0
`define BPB_RESP_DECERR  2'h3

// function-mode bits of port b select register
`define BPB_FN_IRQ_ONE   0
`define BPB_FN_IRQ_TWO   1
`define BPB_FN_TMR_ZERO  2
`define BPB_FN_TMR_ONE   3
`define BPB_FN_TMR_TWO   4
`define BPB_FN_EVT_CNT   5
// pins handed to functions, and those of them that are outputs
`define BPB_FMASK_B      8'h0f
`define BPB_OMASK_B      8'h0c
`define BPB_FMASK_C      8'h30
`define BPB_OMASK_C      8'h10

`endif

// file: rtl/bpb_pkg.sv
// types shared by the port bank modules
`include "bpb_cfg.svh"

package bpb_pkg;

  typedef enum logic [3:0] {
    BPB_REG_NONE,
    BPB_REG_A_DATA,
    BPB_REG_A_DIR,
    BPB_REG_B_DATA,
    BPB_REG_B_DIR,
    BPB_REG_C_DATA,
    BPB_REG_C_DIR,
    BPB_REG_A_OD,
    BPB_REG_B_FUNC,
    BPB_REG_A_PC,
    BPB_REG_B_PC,
    BPB_REG_C_PC
  } bpb_reg_e;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pullup_en;
  } bpb_pad_s;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] od;
    logic [7:0] pc;
  } bpb_pin_cfg_s;

  typedef struct packed {
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [7:0] data_a;
    logic [7:0] data_b;
    logic [7:0] data_c;
    logic [7:0] od_a;
    logic [7:0] pc_a;
    logic [7:0] pc_b;
    logic [7:0] pc_c;
    logic [7:0] mode_b;
    logic       aw_rdy;
    logic       aw_held;
    logic [7:0] aw_idx;
    logic       w_rdy;
    logic       w_held;
    logic [7:0] wdata;
    logic       wlane;
    logic       bvalid;
    logic [1:0] bresp;
    logic       ar_rdy;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic       irq_one;
    logic       irq_two;
    logic       evt_cnt;
  } bpb_state_s;

endpackage

// file: rtl/bpb_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "bpb_cfg.svh"

module bpb_pin_sync
  import bpb_pkg::*;
#(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin_async,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } bpb_sync_s;

  bpb_sync_s st_reg;
  bpb_sync_s st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.s1  = pin_async;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    // a change counts once stages two and three agree
    st_next.lvl = (st_reg.s2 & st_reg.s3) | (st_reg.lvl & (st_reg.s2 ^ st_reg.s3));
    if (srst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign level = st_reg.lvl;

endmodule

// file: rtl/bpb_port_pad.sv
// registered pad driver for one 8-bit port
`timescale 1ns/1ps
`include "bpb_cfg.svh"

module bpb_port_pad
  import bpb_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire bpb_pin_cfg_s cfg_next,
  output bpb_pad_s          pad
);

  bpb_pad_s pad_reg;
  bpb_pad_s pad_next;

  always_comb begin
    // open-drain bits only ever pull low
    pad_next.out       = cfg_next.data & ~cfg_next.od;
    pad_next.oe_n      = ~(cfg_next.dir & (~cfg_next.od | ~cfg_next.data));
    // pull-up off for any output pin
    pad_next.pullup_en = ~cfg_next.dir & ~cfg_next.pc;
    if (srst) begin
      pad_next.out       = `BPB_CFG_RESET;
      pad_next.oe_n      = `BPB_PIN_IDLE;
      pad_next.pullup_en = `BPB_PIN_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    pad_reg <= pad_next;
  end

  assign pad = pad_reg;

  drain_no_high_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> ((~pad_reg.oe_n & pad_reg.out & $past(cfg_next.od)) == 8'h00))
    else $error("open-drain pin driven high");

  pullup_follow_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> (pad_reg.pullup_en == ($past(~cfg_next.dir) & $past(~cfg_next.pc))))
    else $error("pull-up enable wrong for direction and control");

endmodule

// file: rtl/bpb_port_bank.sv
// bidirectional port bank with axi4-lite register slave
`timescale 1ns/1ps
`include "bpb_cfg.svh"
// What this block does
// - direction bit one makes pin output, zero makes it input, per bit.
// - direction register is write-only and resets to zero, all inputs.
// - output pins drive the data register; reads of input pins return level.
// - data register keeps no reset value; undefined until written.
// - open-drain select one gives open-drain, zero push-pull, on outputs.
// - open-drain select is write-only and resets to zero.
// - pull-up control one disables, zero enables the input pull-up.
// - pull-up is switched off automatically while the pin is an output.
// - pull-up control is write-only and resets to zero, pull-ups on.
// - port b mode bit zero gives port use, one gives alternate function.
// - port b mode register is write-only and resets to zero.
// - direction bit decides pin role only while its mode bit is zero.
// - function pins: two irq inputs, three timer outputs, one event input.
// - port a data and direction sit at consecutive indices c0 and c1.
// - port b data and direction follow at indices c2 and c3.
// - port c data and direction at c4, c5; pull-up control at fa.

module bpb_port_bank
  import bpb_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        port_a_pin_in,
  input  wire logic [7:0]        port_b_pin_in,
  input  wire logic [7:0]        port_c_pin_in,
  output bpb_pad_s               port_a_pad,
  output bpb_pad_s               port_b_pad,
  output bpb_pad_s               port_c_pad,
  input  wire logic              timer_zero_output,
  input  wire logic              timer_one_output,
  input  wire logic              timer_two_output,
  output logic                   external_irq_one_input,
  output logic                   external_irq_two_input,
  output logic                   event_count_input
);

  bpb_state_s   st_reg;
  bpb_state_s   st_next;
  logic [23:0]  pin_lvl;
  logic         aw_fire;
  logic         w_fire;
  logic         ar_fire;
  logic         wr_do;
  bpb_reg_e     wr_reg;
  bpb_reg_e     rd_reg;
  logic [7:0]   tmr_b;
  logic [7:0]   tmr_c;
  bpb_pin_cfg_s cfg_a_next;
  bpb_pin_cfg_s cfg_b_next;
  bpb_pin_cfg_s cfg_c_next;

  function automatic bpb_reg_e reg_decode(input logic [7:0] idx);
    if (idx == `BPB_IDX_A_DATA) begin
      reg_decode = BPB_REG_A_DATA;
    end else if (idx == `BPB_IDX_A_DIR) begin
      reg_decode = BPB_REG_A_DIR;
    end else if (idx == `BPB_IDX_B_DATA) begin
      reg_decode = BPB_REG_B_DATA;
    end else if (idx == `BPB_IDX_B_DIR) begin
      reg_decode = BPB_REG_B_DIR;
    end else if (idx == `BPB_IDX_C_DATA) begin
      reg_decode = BPB_REG_C_DATA;
    end else if (idx == `BPB_IDX_C_DIR) begin
      reg_decode = BPB_REG_C_DIR;
    end else if (idx == `BPB_IDX_A_OD) begin
      reg_decode = BPB_REG_A_OD;
    end else if (idx == `BPB_IDX_B_FUNC) begin
      reg_decode = BPB_REG_B_FUNC;
    end else if (idx == `BPB_IDX_A_PC) begin
      reg_decode = BPB_REG_A_PC;
    end else if (idx == `BPB_IDX_B_PC) begin
      reg_decode = BPB_REG_B_PC;
    end else if (idx == `BPB_IDX_C_PC) begin
      reg_decode = BPB_REG_C_PC;
    end else begin
      reg_decode = BPB_REG_NONE;
    end
  endfunction

  // outputs read back the data register, inputs the pin level
  function automatic logic [7:0] port_rd(input logic [7:0] dir,
                                         input logic [7:0] data,
                                         input logic [7:0] lvl);
    port_rd = (dir & data) | (~dir & lvl);
  endfunction

  // direction after the function select takes its pins over
  function automatic logic [7:0] eff_dir(input logic [7:0] dir,
                                         input logic [7:0] mode,
                                         input logic [7:0] fmask,
                                         input logic [7:0] omask);
    eff_dir = (dir & ~(mode & fmask)) | (mode & omask);
  endfunction

  function automatic logic [7:0] eff_data(input logic [7:0] data,
                                          input logic [7:0] mode,
                                          input logic [7:0] omask,
                                          input logic [7:0] tmr);
    eff_data = (data & ~(mode & omask)) | (mode & omask & tmr);
  endfunction

  bpb_pin_sync #(
    .W (24)
  ) u_sync (
    .clk       (clk),
    .srst      (srst),
    .pin_async ({port_c_pin_in, port_b_pin_in, port_a_pin_in}),
    .level     (pin_lvl)
  );

  always_comb begin
    st_next = st_reg;
    aw_fire = s_axi_awvalid & st_reg.aw_rdy;
    w_fire  = s_axi_wvalid & st_reg.w_rdy;
    ar_fire = s_axi_arvalid & st_reg.ar_rdy;
    wr_do   = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
    wr_reg  = reg_decode(st_reg.aw_idx);
    rd_reg  = reg_decode(s_axi_araddr[`BPB_IDX_MSB:`BPB_IDX_LSB]);

    if (aw_fire) begin
      st_next.aw_held = 1'b1;
      st_next.aw_idx  = s_axi_awaddr[`BPB_IDX_MSB:`BPB_IDX_LSB];
    end
    if (w_fire) begin
      st_next.w_held = 1'b1;
      st_next.wdata  = s_axi_wdata[7:0];
      st_next.wlane  = s_axi_wstrb[0];
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // whole byte stored at once; no merge with earlier contents
    if (wr_do) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = (wr_reg == BPB_REG_NONE) ? `BPB_RESP_DECERR : `BPB_RESP_OKAY;
      if (st_reg.wlane) begin
        case (wr_reg)
          BPB_REG_A_DATA: st_next.data_a = st_reg.wdata;
          BPB_REG_A_DIR:  st_next.dir_a  = st_reg.wdata;
          BPB_REG_B_DATA: st_next.data_b = st_reg.wdata;
          BPB_REG_B_DIR:  st_next.dir_b  = st_reg.wdata;
          BPB_REG_C_DATA: st_next.data_c = st_reg.wdata;
          BPB_REG_C_DIR:  st_next.dir_c  = st_reg.wdata;
          BPB_REG_A_OD:   st_next.od_a   = st_reg.wdata;
          BPB_REG_B_FUNC: st_next.mode_b = st_reg.wdata;
          BPB_REG_A_PC:   st_next.pc_a   = st_reg.wdata;
          BPB_REG_B_PC:   st_next.pc_b   = st_reg.wdata;
          BPB_REG_C_PC:   st_next.pc_c   = st_reg.wdata;
          default: begin
          end
        endcase
      end
    end

    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (ar_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `BPB_RESP_OKAY;
      st_next.rdata  = `BPB_CFG_RESET;
      // write-only registers read as zero
      case (rd_reg)
        BPB_REG_A_DATA: begin
          st_next.rdata = port_rd(st_reg.dir_a, st_reg.data_a, pin_lvl[7:0]);
        end
        BPB_REG_B_DATA: begin
          st_next.rdata = port_rd(st_reg.dir_b & ~(st_reg.mode_b & `BPB_FMASK_B),
                                  st_reg.data_b, pin_lvl[15:8]);
        end
        BPB_REG_C_DATA: begin
          st_next.rdata = port_rd(st_reg.dir_c & ~(st_reg.mode_b & `BPB_FMASK_C),
                                  st_reg.data_c, pin_lvl[23:16]);
        end
        BPB_REG_NONE: begin
          st_next.rresp = `BPB_RESP_DECERR;
        end
        default: begin
        end
      endcase
    end

    // function inputs pass the filtered pin level on
    st_next.irq_one = st_reg.mode_b[`BPB_FN_IRQ_ONE] & pin_lvl[8 + `BPB_FN_IRQ_ONE];
    st_next.irq_two = st_reg.mode_b[`BPB_FN_IRQ_TWO] & pin_lvl[8 + `BPB_FN_IRQ_TWO];
    st_next.evt_cnt = st_reg.mode_b[`BPB_FN_EVT_CNT] & pin_lvl[16 + `BPB_FN_EVT_CNT];

    st_next.aw_rdy = ~st_next.aw_held;
    st_next.w_rdy  = ~st_next.w_held;
    st_next.ar_rdy = ~st_next.rvalid;

    // data registers deliberately keep their contents through reset
    if (srst) begin
      st_next.dir_a   = `BPB_CFG_RESET;
      st_next.dir_b   = `BPB_CFG_RESET;
      st_next.dir_c   = `BPB_CFG_RESET;
      st_next.od_a    = `BPB_CFG_RESET;
      st_next.pc_a    = `BPB_CFG_RESET;
      st_next.pc_b    = `BPB_CFG_RESET;
      st_next.pc_c    = `BPB_CFG_RESET;
      st_next.mode_b  = `BPB_CFG_RESET;
      st_next.aw_rdy  = 1'b0;
      st_next.aw_held = 1'b0;
      st_next.aw_idx  = `BPB_CFG_RESET;
      st_next.w_rdy   = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.wdata   = `BPB_CFG_RESET;
      st_next.wlane   = 1'b0;
      st_next.bvalid  = 1'b0;
      st_next.bresp   = `BPB_RESP_OKAY;
      st_next.ar_rdy  = 1'b0;
      st_next.rvalid  = 1'b0;
      st_next.rresp   = `BPB_RESP_OKAY;
      st_next.rdata   = `BPB_CFG_RESET;
      st_next.irq_one = 1'b0;
      st_next.irq_two = 1'b0;
      st_next.evt_cnt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // timer outputs placed on their pin positions
  assign tmr_b = {4'h0, timer_one_output, timer_zero_output, 2'h0};
  assign tmr_c = {3'h0, timer_two_output, 4'h0};

  // pads take the next register values, so a write shows on the pad at the same edge as in the register
  assign cfg_a_next = '{dir: st_next.dir_a, data: st_next.data_a,
                        od: st_next.od_a, pc: st_next.pc_a};
  assign cfg_b_next = '{dir:  eff_dir(st_next.dir_b, st_next.mode_b, `BPB_FMASK_B, `BPB_OMASK_B),
                        data: eff_data(st_next.data_b, st_next.mode_b, `BPB_OMASK_B, tmr_b),
                        od:   `BPB_CFG_RESET, pc: st_next.pc_b};
  assign cfg_c_next = '{dir:  eff_dir(st_next.dir_c, st_next.mode_b, `BPB_FMASK_C, `BPB_OMASK_C),
                        data: eff_data(st_next.data_c, st_next.mode_b, `BPB_OMASK_C, tmr_c),
                        od:   `BPB_CFG_RESET, pc: st_next.pc_c};

  bpb_port_pad u_pad_a (
    .clk      (clk),
    .srst     (srst),
    .cfg_next (cfg_a_next),
    .pad      (port_a_pad)
  );

  bpb_port_pad u_pad_b (
    .clk      (clk),
    .srst     (srst),
    .cfg_next (cfg_b_next),
    .pad      (port_b_pad)
  );

  bpb_port_pad u_pad_c (
    .clk      (clk),
    .srst     (srst),
    .cfg_next (cfg_c_next),
    .pad      (port_c_pad)
  );

  assign s_axi_awready          = st_reg.aw_rdy;
  assign s_axi_wready           = st_reg.w_rdy;
  assign s_axi_bvalid           = st_reg.bvalid;
  assign s_axi_bresp            = st_reg.bresp;
  assign s_axi_arready          = st_reg.ar_rdy;
  assign s_axi_rvalid           = st_reg.rvalid;
  assign s_axi_rresp            = st_reg.rresp;
  assign s_axi_rdata            = {24'h0, st_reg.rdata};
  assign external_irq_one_input = st_reg.irq_one;
  assign external_irq_two_input = st_reg.irq_two;
  assign event_count_input      = st_reg.evt_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence both_held_s;
    st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
  endsequence

  sequence resp_up_s;
    st_reg.bvalid && !st_reg.aw_held && !st_reg.w_held;
  endsequence

  bus_write_resp_a: assert property (both_held_s |=> resp_up_s)
    else $error("write response not raised one cycle after address and data");

  dir_write_a: assert property (
    wr_do && st_reg.wlane && wr_reg == BPB_REG_A_DIR |=> st_reg.dir_a == $past(st_reg.wdata))
    else $error("port a direction write not stored");

  read_input_a: assert property (
    ar_fire && rd_reg == BPB_REG_A_DATA && st_reg.dir_a == 8'h00
    |=> st_reg.rvalid && st_reg.rdata == $past(pin_lvl[7:0]))
    else $error("input pin read does not return pin level");

  reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> st_reg.dir_a == 8'h00 && st_reg.od_a == 8'h00 && st_reg.pc_c == 8'h00
             && st_reg.mode_b == 8'h00 && port_b_pad.oe_n == 8'hff)
    else $error("control registers not cleared by reset");

  timer_func_a: assert property (
    st_next.mode_b[2] |=> !port_b_pad.oe_n[2] && port_b_pad.out[2] == $past(timer_zero_output))
    else $error("timer zero output not on port b pin 2");

  irq_func_a: assert property (
    st_reg.mode_b[0] |=> external_irq_one_input == $past(pin_lvl[8]))
    else $error("external irq one does not follow port b pin 0");

  gpio_mode_a: assert property (
    !st_next.mode_b[1] |=> port_b_pad.oe_n[1] == !$past(st_next.dir_b[1]))
    else $error("port b pin 1 direction ignored in port mode");

endmodule

// file: dv/bpb_pin_model.sv
// board-side model of eight port pins with external drivers
`timescale 1ns/1ps

module bpb_pin_model
  import bpb_pkg::*;
(
  input  wire logic       clk,
  input  wire bpb_pad_s   pad,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin
);
  logic [7:0] flt = 8'h55;

  // an undriven pin without pull-up wanders every cycle
  always @(posedge clk) flt <= ~flt;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad.oe_n[i]) pin[i] = pad.out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (pad.pullup_en[i]) pin[i] = 1'b1;
      else pin[i] = flt[i];
    end
  end
endmodule

// file: dv/bpb_port_bank_tb.sv
// register-level tests of the port bank through its axi4-lite slave
`timescale 1ns/1ps

module bpb_port_bank_tb
  import bpb_pkg::*;
;
  logic        clk, srst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  pin_a, pin_b, pin_c, ev_a, ev_b, ev_c, en_a, en_b, en_c;
  bpb_pad_s    pad_a, pad_b, pad_c;
  logic        tmr0, tmr1, tmr2, irq1, irq2, evt;
  int          num_errors = 0;
  int          compares = 0;

  bpb_port_bank u_dut (.clk(clk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port_a_pin_in(pin_a), .port_b_pin_in(pin_b),
    .port_c_pin_in(pin_c), .port_a_pad(pad_a), .port_b_pad(pad_b), .port_c_pad(pad_c),
    .timer_zero_output(tmr0), .timer_one_output(tmr1), .timer_two_output(tmr2),
    .external_irq_one_input(irq1), .external_irq_two_input(irq2),
    .event_count_input(evt));

  bpb_pin_model u_pa (.clk(clk), .pad(pad_a), .ext_val(ev_a), .ext_en(en_a), .pin(pin_a));
  bpb_pin_model u_pb (.clk(clk), .pad(pad_b), .ext_val(ev_b), .ext_en(en_b), .pin(pin_b));
  bpb_pin_model u_pc (.clk(clk), .pad(pad_c), .ext_val(ev_c), .ext_en(en_c), .pin(pin_c));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("counts: errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // whole-byte writes on lane 0; strobe set by the caller, lane 0 alone by default
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er,
                    input logic [3:0] s = 4'h1);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    chk({6'h0, s_axi_bresp}, {6'h0, er});
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata[7:0], ed);
    chk(s_axi_rdata[31:24] | s_axi_rdata[23:16] | s_axi_rdata[15:8], 8'h00);
    chk({6'h0, s_axi_rresp}, {6'h0, er});
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_pad(input bpb_pad_s p, input logic [7:0] o, input logic [7:0] oe,
                         input logic [7:0] pu);
    chk(p.out, o);
    chk(p.oe_n, oe);
    chk(p.pullup_en, pu);
  endtask

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    srst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ev_a, ev_b, ev_c, en_a, en_b, en_c} = '0;
    {tmr0, tmr1, tmr2} = '0;
    do_reset();
    chk_pad(pad_a, 8'h00, 8'hff, 8'hff);
    rd(12'h304, 8'h00, 2'h0);
    rd(12'h390, 8'h00, 2'h0);
    rd(12'h3c4, 8'h00, 2'h0);
    $display("test reset done");
    wr(12'h300, 8'ha5, 2'h0);
    wr(12'h304, 8'h0f, 2'h0);
    chk_pad(pad_a, 8'ha5, 8'hf0, 8'hf0);
    repeat (6) @(posedge clk);
    rd(12'h300, 8'hf5, 2'h0);
    ev_a <= 8'h00;
    en_a <= 8'hf0;
    repeat (6) @(posedge clk);
    rd(12'h300, 8'h05, 2'h0);
    wr(12'h390, 8'h03, 2'h0);
    chk_pad(pad_a, 8'ha4, 8'hf1, 8'hf0);
    wr(12'h3e0, 8'hc0, 2'h0);
    chk_pad(pad_a, 8'ha4, 8'hf1, 8'h30);
    wr(12'h304, 8'hff, 2'h0, 4'h0);
    chk_pad(pad_a, 8'ha4, 8'hf1, 8'h30);
    $display("test port a done");
    wr(12'h308, 8'h3c, 2'h0);
    wr(12'h30c, 8'hf0, 2'h0);
    chk_pad(pad_b, 8'h3c, 8'h0f, 8'h0f);
    wr(12'h3e4, 8'h01, 2'h0);
    chk_pad(pad_b, 8'h3c, 8'h0f, 8'h0e);
    wr(12'h310, 8'h81, 2'h0);
    wr(12'h314, 8'hff, 2'h0);
    chk_pad(pad_c, 8'h81, 8'h00, 8'h00);
    rd(12'h310, 8'h81, 2'h0);
    wr(12'h3e8, 8'h0f, 2'h0);
    wr(12'h314, 8'h00, 2'h0);
    chk(pad_c.pullup_en, 8'hf0);
    $display("test ports b and c done");
    wr(12'h30c, 8'h00, 2'h0);
    ev_b <= 8'h01;
    en_b <= 8'h03;
    tmr0 <= 1'b1;
    tmr2 <= 1'b1;
    wr(12'h3c4, 8'h3f, 2'h0);
    repeat (6) @(posedge clk);
    chk(pad_b.oe_n, 8'hf3);
    chk(pad_b.out & 8'h0c, 8'h04);
    chk(pad_c.oe_n, 8'hef);
    chk(pad_c.out & 8'h10, 8'h10);
    chk({5'h0, irq1, irq2, evt}, 8'h05);
    tmr0 <= 1'b0;
    tmr1 <= 1'b1;
    ev_b <= 8'h02;
    repeat (6) @(posedge clk);
    chk(pad_b.out & 8'h0c, 8'h08);
    chk({5'h0, irq1, irq2, evt}, 8'h03);
    rd(12'h308, 8'hfa, 2'h0);
    wr(12'h3c4, 8'h00, 2'h0);
    repeat (6) @(posedge clk);
    chk(pad_b.oe_n, 8'hff);
    chk(pad_c.oe_n, 8'hff);
    chk({5'h0, irq1, irq2, evt}, 8'h00);
    $display("test function mode done");
    wr(12'h200, 8'hff, 2'h3);
    rd(12'h200, 8'h00, 2'h3);
    $display("test unmapped done");
    do_reset();
    chk_pad(pad_a, 8'h00, 8'hff, 8'hff);
    chk_pad(pad_b, 8'h00, 8'hff, 8'hff);
    repeat (6) @(posedge clk);
    rd(12'h300, 8'h0f, 2'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule
